// ### hw/fsq_defines.svh
// Purpose: Constants of the flash program/erase sequencer and its host controller.
// Assumes: One 32-bit link between host end and device end.
// Notes:   Offsets, register field positions, keys and cycle counts live here; the host command op and size fields are coded in place.
`ifndef FSQ_DEFINES_SVH
`define FSQ_DEFINES_SVH
`define FSQ_FIRST_UNLOCK_WORD      32'h45670123
`define FSQ_SECOND_UNLOCK_WORD      32'hCDEF89AB
// Device map: register page and flash window
`define FSQ_REG_BASE  24'h400220
`define FSQ_FLASH_HI  8'h08
`define FSQ_OFF_KEY   8'h04
`define FSQ_OFF_STAT  8'h0C
`define FSQ_OFF_CTL   8'h10
`define FSQ_OFF_ADDR  8'h14
`define FSQ_OFF_MKEY  8'h24
// Control and status fields
`define FSQ_C_PG      0
`define FSQ_C_PER     1
`define FSQ_C_MER     2
`define FSQ_C_STRT    6
`define FSQ_C_LOCK    7
`define FSQ_C_FAST_GUARD_BIT   15
`define FSQ_C_FAST_PROGRAM_ENABLE    16
`define FSQ_C_PGER    17
`define FSQ_C_BLOAD   18
`define FSQ_C_BRST    19
`define FSQ_S_BSY     0
`define FSQ_S_EOP     5
`define FSQ_LOCKED    1'b1
`define FSQ_SZ_HALF   2'h1
`define FSQ_SZ_WORD   2'h2
`define FSQ_BUF_WORDS 16
`define FSQ_LAST_WORD 4'hF
// Operation lengths in cycles
`define FSQ_T_HALF    16'h0020
`define FSQ_T_PAGE    16'h0100
`define FSQ_T_CHIP    16'h0400
`define FSQ_T_FAST    16'h0080
`define FSQ_T_BUF     16'h0002
// Host controller registers on AHB-Lite
`define FSQ_H_CMD     8'h00
`define FSQ_H_ADR     8'h04
`define FSQ_H_WDT     8'h08
`define FSQ_H_STS     8'h0C
`define FSQ_H_RDT     8'h10
`define FSQ_OP_WR     3'h0
`define FSQ_OP_RD     3'h1
`define FSQ_OP_UNLK   3'h2
`define FSQ_OP_FUNLK  3'h3
`define FSQ_OP_WAIT   3'h4
`define FSQ_HS_RUN    0
`define FSQ_HS_ERR    1
`endif

// ### hw/fsq_pkg.sv
// Purpose: Types shared by both ends of the flash sequencer.
// Assumes: Nothing beyond the defines header.
// Notes:   Enumerations carry no explicit codes.
package fsq_pkg;
    typedef enum logic [2:0] {FSQ_K_HALF, FSQ_K_PAGE, FSQ_K_CHIP, FSQ_K_FPROG, FSQ_K_FERASE,
                              FSQ_K_BUF} fsq_kind_t;
    typedef enum logic [1:0] {FSQ_D_IDLE, FSQ_D_STREAM, FSQ_D_WAIT} fsq_dstate_t;
    typedef enum logic [1:0] {FSQ_H_IDLE, FSQ_H_REQ} fsq_hstate_t;
    typedef struct packed {
        logic        we;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] data;
    } fsq_acc_t;
endpackage : fsq_pkg

// ### hw/fsq_link_if.sv
// Purpose: Register link between host controller and flash sequencer.
// Assumes: Request held until acknowledged; one answer per request.
// Notes:   No clocking block; both ends share ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface fsq_link_if;
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
    modport dev  (input req, we, size, addr, wdata, output ack, err, rdata);
    modport host (output req, we, size, addr, wdata, input ack, err, rdata);
endinterface : fsq_link_if
`default_nettype wire

// ### hw/fsq_op_timer.sv
// Purpose: Counts the length of one program, erase or buffer operation.
// Assumes: start is a one-cycle pulse; len is at least one.
// Notes:   done pulses len+1 cycles after start.
`timescale 1ns/1ps
`default_nettype none
module fsq_op_timer #(
    parameter int unsigned W = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         start,
    input  wire logic [W-1:0] len,
    output logic              done
);
    logic [W-1:0] cnt_r;

    // Down counter, reloaded by each start
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= len;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end

    // Registered end pulse so the sequencer sees a clean event
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done <= 1'b0;
        end else begin
            done <= !start && (cnt_r == W'(1));
        end
    end
endmodule : fsq_op_timer
`default_nettype wire

// ### hw/fsq_device.sv
// Purpose: Flash program/erase sequencer: keys, control, status, page buffer.
// Assumes: Link requests are held until ack; array port accepts every strobe.
// Notes:   Flash reads return zero here; the array read path is elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "fsq_defines.svh"
module fsq_device
    import fsq_pkg::*;
#(
    parameter logic [15:0] T_HALF = `FSQ_T_HALF,
    parameter logic [15:0] T_PAGE = `FSQ_T_PAGE,
    parameter logic [15:0] T_CHIP = `FSQ_T_CHIP,
    parameter logic [15:0] T_FAST = `FSQ_T_FAST,
    parameter logic [15:0] T_BUF  = `FSQ_T_BUF
) (
    input  wire logic   ref_clk,
    input  wire logic   sys_rst,
    fsq_link_if.dev     link,
    output logic        arr_stb,
    output fsq_kind_t   arr_kind,
    output logic [31:0] arr_addr,
    output logic [31:0] arr_data,
    output logic        op_busy
);
    // Key step: returns {stage_nxt, dead, open}
    function automatic logic [2:0] key_step(input logic stage, input logic wr,
                                            input logic other, input logic [31:0] d);
        logic [2:0] r;
        r = {stage, 2'b00};
        if (wr) begin
            if (!stage && d == `FSQ_FIRST_UNLOCK_WORD) r = 3'b100;
            else if (stage && d == `FSQ_SECOND_UNLOCK_WORD) r = 3'b001;
            else r = 3'b010;
        end else if (other && stage) begin
            r = 3'b010; // A foreign access between the two words breaks the pair
        end
        return r;
    endfunction : key_step

    fsq_dstate_t state_r;
    logic        ack_r, err_r;
    logic [31:0] rdata_r;
    logic        lock_r, dead_r, kstage_r;
    logic        fast_guard_bit_r, fdead_r, fstage_r;
    logic        pg_r, per_r, mer_r, fast_program_enable_r, pger_r;
    logic        done_r;
    logic [31:0] addr_r, stage_data_r;
    logic [3:0]  stage_idx_r, widx_r;
    logic [31:0] buf_r [`FSQ_BUF_WORDS];
    logic        tdone;

    logic        take, wr, is_reg, is_fl, busy, bad;
    logic [7:0]  off;
    logic        w_key, w_mkey, w_ctl, w_stat, w_addr, fl_wr;
    logic [2:0]  kz, fz;
    logic [31:0] nw, rd;
    logic [4:0]  modes;
    logic        go, st_pg, st_per, st_mer, st_fp, st_fe, brst, bload, stage_w;
    logic        tstart;
    logic [15:0] tlen;

    assign busy        = (state_r != FSQ_D_IDLE);
    assign op_busy     = busy;
    assign link.ack    = ack_r;
    assign link.err    = err_r;
    assign link.rdata  = rdata_r;

    // Access decode; every register effect is gated here
    always_comb begin
        take   = link.req && !ack_r;
        wr     = take && link.we;
        is_reg = (link.addr[31:8] == `FSQ_REG_BASE);
        is_fl  = (link.addr[31:24] == `FSQ_FLASH_HI);
        off    = link.addr[7:0];
        nw     = link.wdata;
        w_key  = wr && is_reg && off == `FSQ_OFF_KEY;
        w_mkey = wr && is_reg && off == `FSQ_OFF_MKEY;
        kz = key_step(kstage_r, w_key && lock_r && !dead_r, take && !w_key, nw);
        fz = key_step(fstage_r, w_mkey && fast_guard_bit_r && !fdead_r, take && !w_mkey, nw);
        w_ctl  = wr && is_reg && off == `FSQ_OFF_CTL && !lock_r && !dead_r && !busy;
        w_stat = wr && is_reg && off == `FSQ_OFF_STAT && !dead_r && !busy;
        w_addr = wr && is_reg && off == `FSQ_OFF_ADDR && !dead_r && !busy;
        fl_wr  = wr && is_fl && !lock_r && !dead_r && !busy;
        st_pg  = fl_wr && pg_r && link.size == `FSQ_SZ_HALF;
        stage_w = fl_wr && !pg_r && fast_program_enable_r && link.size == `FSQ_SZ_WORD;
        // Dead controller answers register accesses and flash writes with an error; flash reads get no error
        bad = dead_r && (is_reg || (is_fl && link.we));
        bad = bad || (wr && is_fl && pg_r && !lock_r && link.size != `FSQ_SZ_HALF);
        modes = {nw[`FSQ_C_PG], nw[`FSQ_C_PER], nw[`FSQ_C_MER], nw[`FSQ_C_FAST_PROGRAM_ENABLE],
                 nw[`FSQ_C_PGER]};
        go     = w_ctl && nw[`FSQ_C_STRT] && $onehot(modes);
        st_per = go && nw[`FSQ_C_PER];
        st_mer = go && nw[`FSQ_C_MER];
        st_fp  = go && nw[`FSQ_C_FAST_PROGRAM_ENABLE] && !fast_guard_bit_r;
        st_fe  = go && nw[`FSQ_C_PGER] && !fast_guard_bit_r;
        brst   = w_ctl && nw[`FSQ_C_BRST] && nw[`FSQ_C_FAST_PROGRAM_ENABLE] && !fast_guard_bit_r;
        bload  = w_ctl && nw[`FSQ_C_BLOAD] && nw[`FSQ_C_FAST_PROGRAM_ENABLE] && !fast_guard_bit_r && !brst;
    end

    // Timer start and length per operation kind
    always_comb begin
        tstart = 1'b1;
        tlen   = T_BUF;
        if (st_pg) tlen = T_HALF;
        else if (st_per) tlen = T_PAGE;
        else if (st_mer) tlen = T_CHIP;
        else if (st_fe) tlen = T_FAST;
        else if (state_r == FSQ_D_STREAM && widx_r == `FSQ_LAST_WORD) tlen = T_FAST;
        else if (!(brst || bload)) tstart = 1'b0;
    end

    fsq_op_timer #(.W(16)) u_timer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .start   (tstart),
        .len     (tlen),
        .done    (tdone)
    );

    // Read data mux
    always_comb begin
        rd = '0;
        if (is_reg && off == `FSQ_OFF_STAT) begin
            rd[`FSQ_S_BSY] = busy;
            rd[`FSQ_S_EOP] = done_r;
        end else if (is_reg && off == `FSQ_OFF_CTL) begin
            rd[`FSQ_C_PG]    = pg_r;
            rd[`FSQ_C_PER]   = per_r;
            rd[`FSQ_C_MER]   = mer_r;
            rd[`FSQ_C_LOCK]  = lock_r;
            rd[`FSQ_C_FAST_GUARD_BIT] = fast_guard_bit_r;
            rd[`FSQ_C_FAST_PROGRAM_ENABLE]  = fast_program_enable_r;
            rd[`FSQ_C_PGER]  = pger_r;
        end else if (is_reg && off == `FSQ_OFF_ADDR) begin
            rd = addr_r;
        end
    end

    // Link answer, one cycle after the request is taken
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_r   <= 1'b0;
            err_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r   <= take;
            err_r   <= take && bad;
            rdata_r <= (take && !link.we && !bad) ? rd : '0;
        end
    end

    // Main key: locked from reset, dead after a bad sequence
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_r   <= `FSQ_LOCKED;
            kstage_r <= 1'b0;
            dead_r   <= 1'b0;
        end else begin
            kstage_r <= kz[2];
            if (kz[1]) dead_r <= 1'b1;
            if (kz[0]) lock_r <= 1'b0;
            else if (w_ctl && nw[`FSQ_C_LOCK]) lock_r <= 1'b1;
        end
    end

    // Fast key: separate guard, blocked for good after a bad sequence
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fast_guard_bit_r  <= `FSQ_LOCKED;
            fstage_r <= 1'b0;
            fdead_r  <= 1'b0;
        end else begin
            fstage_r <= fz[2];
            if (fz[1]) fdead_r <= 1'b1;
            if (fz[0]) fast_guard_bit_r <= 1'b0;
            else if (w_ctl && nw[`FSQ_C_FAST_GUARD_BIT]) fast_guard_bit_r <= 1'b1;
        end
    end

    // Mode enables and target address
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {pg_r, per_r, mer_r, fast_program_enable_r, pger_r} <= '0;
            addr_r <= '0;
        end else begin
            if (w_ctl) {pg_r, per_r, mer_r, fast_program_enable_r, pger_r} <= modes;
            if (w_addr) addr_r <= nw;
        end
    end

    // Done flag: hardware set wins over a write-one clear
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= tdone || (done_r && !(w_stat && nw[`FSQ_S_EOP]));
        end
    end

    // Staging word and page buffer; no reset, cleared by its trigger
    always_ff @(posedge ref_clk) begin
        if (stage_w) begin
            stage_data_r <= nw;
            stage_idx_r  <= link.addr[5:2];
        end
        if (brst) begin
            for (int i = 0; i < `FSQ_BUF_WORDS; i++) buf_r[i] <= '0;
        end else if (bload) begin
            buf_r[stage_idx_r] <= stage_data_r;
        end
    end

    // Sequencer: busy from start until timer end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= FSQ_D_IDLE;
            widx_r  <= '0;
        end else begin
            unique case (state_r)
                FSQ_D_IDLE: begin
                    widx_r <= '0;
                    if (st_fp) state_r <= FSQ_D_STREAM;
                    else if (tstart) state_r <= FSQ_D_WAIT;
                end
                FSQ_D_STREAM: begin
                    widx_r <= widx_r + 4'h1;
                    if (widx_r == `FSQ_LAST_WORD) state_r <= FSQ_D_WAIT;
                end
                FSQ_D_WAIT: begin
                    if (tdone) state_r <= FSQ_D_IDLE;
                end
            endcase
        end
    end

    // Array strobes; a fast page streams sixteen words on back-to-back cycles
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            arr_stb  <= 1'b0;
            arr_kind <= FSQ_K_HALF;
            arr_addr <= '0;
            arr_data <= '0;
        end else begin
            arr_stb <= st_pg || st_per || st_mer || st_fe || (state_r == FSQ_D_STREAM);
            if (st_pg) begin
                arr_kind <= FSQ_K_HALF;
                arr_addr <= link.addr;
                arr_data <= {16'h0000, link.addr[1] ? nw[31:16] : nw[15:0]};
            end else if (st_per || st_mer || st_fe) begin
                arr_kind <= st_per ? FSQ_K_PAGE : (st_mer ? FSQ_K_CHIP : FSQ_K_FERASE);
                arr_addr <= addr_r;
                arr_data <= '0;
            end else if (state_r == FSQ_D_STREAM) begin
                arr_kind <= FSQ_K_FPROG;
                arr_addr <= {addr_r[31:6], widx_r, 2'b00};
                arr_data <= buf_r[widx_r];
            end
        end
    end
endmodule : fsq_device
`default_nettype wire

// ### hw/fsq_host.sv
// Purpose: Host end: runs link accesses and key/poll sequences ordered over AHB-Lite.
// Assumes: Single-word AHB-Lite transfers; zero wait states, always OKAY.
// Notes:   Command writes while a command runs are dropped.
`timescale 1ns/1ps
`default_nettype none
`include "fsq_defines.svh"
module fsq_host
    import fsq_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    fsq_link_if.host         link
);
    // Access of a command step
    function automatic fsq_acc_t acc_of(input logic [2:0] op, input logic step,
                                        input logic [1:0] sz, input logic [31:0] a,
                                        input logic [31:0] d);
        fsq_acc_t r;
        r = '{we: 1'b1, size: sz, addr: a, data: d};
        unique case (op)
            `FSQ_OP_RD: r.we = 1'b0;
            `FSQ_OP_UNLK, `FSQ_OP_FUNLK: begin
                r.size = `FSQ_SZ_WORD;
                r.addr = {`FSQ_REG_BASE, (op == `FSQ_OP_UNLK) ? `FSQ_OFF_KEY : `FSQ_OFF_MKEY};
                r.data = step ? `FSQ_SECOND_UNLOCK_WORD : `FSQ_FIRST_UNLOCK_WORD;
            end
            `FSQ_OP_WAIT: begin
                r.we   = step;
                r.size = `FSQ_SZ_WORD;
                r.addr = {`FSQ_REG_BASE, `FSQ_OFF_STAT};
                r.data = 32'h00000000 | (32'h00000001 << `FSQ_S_EOP);
            end
            default: ;
        endcase
        return r;
    endfunction : acc_of

    fsq_hstate_t state_r;
    logic [2:0]  op_r;
    logic [1:0]  sz_r;
    logic [31:0] adr_r, wdt_r, rdt_r;
    logic        err_r, step_r;
    logic        dph_wr_r;
    logic [7:0]  dph_off_r;
    fsq_acc_t    acc_r;
    logic        aphase, cmd_go, last, repoll;
    logic [31:0] rd;

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign link.req   = (state_r == FSQ_H_REQ);
    assign link.we    = acc_r.we;
    assign link.size  = acc_r.size;
    assign link.addr  = acc_r.addr;
    assign link.wdata = acc_r.data;

    // AHB decode; a new command only when idle
    always_comb begin
        aphase = hsel && htrans[1] && hready;
        cmd_go = dph_wr_r && dph_off_r == `FSQ_H_CMD && state_r == FSQ_H_IDLE;
        last   = (op_r == `FSQ_OP_WR) || (op_r == `FSQ_OP_RD) || step_r;
        // Polling repeats while busy reads one, so fast ops start on a quiet device
        repoll = (op_r == `FSQ_OP_WAIT) && !step_r && link.rdata[`FSQ_S_BSY];
        rd = '0;
        unique case (haddr[7:0])
            `FSQ_H_CMD: rd[2:0] = op_r;
            `FSQ_H_ADR: rd = adr_r;
            `FSQ_H_WDT: rd = wdt_r;
            `FSQ_H_STS: begin
                rd[`FSQ_HS_RUN] = (state_r != FSQ_H_IDLE);
                rd[`FSQ_HS_ERR] = err_r;
            end
            `FSQ_H_RDT: rd = rdt_r;
            default: rd = '0;
        endcase
    end

    // AHB address phase capture and read data
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dph_wr_r  <= 1'b0;
            dph_off_r <= '0;
            hrdata    <= '0;
        end else begin
            dph_wr_r  <= aphase && hwrite;
            dph_off_r <= haddr[7:0];
            if (aphase && !hwrite) hrdata <= rd;
        end
    end

    // Order registers written in the data phase
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_r  <= `FSQ_OP_WR;
            sz_r  <= `FSQ_SZ_WORD;
            adr_r <= '0;
            wdt_r <= '0;
        end else if (dph_wr_r && state_r == FSQ_H_IDLE) begin
            if (dph_off_r == `FSQ_H_CMD) begin
                op_r <= hwdata[2:0];
                sz_r <= hwdata[9:8];
            end
            if (dph_off_r == `FSQ_H_ADR) adr_r <= hwdata;
            if (dph_off_r == `FSQ_H_WDT) wdt_r <= hwdata;
        end
    end

    // Link sequencing: request held until ack, next step issued back to back
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= FSQ_H_IDLE;
            step_r  <= 1'b0;
            err_r   <= 1'b0;
            rdt_r   <= '0;
            acc_r   <= '0;
        end else begin
            unique case (state_r)
                FSQ_H_IDLE: begin
                    if (cmd_go) begin
                        state_r <= FSQ_H_REQ;
                        step_r  <= 1'b0;
                        err_r   <= 1'b0;
                        acc_r   <= acc_of(hwdata[2:0], 1'b0, hwdata[9:8], adr_r, wdt_r);
                    end
                end
                FSQ_H_REQ: begin
                    if (link.ack) begin
                        if (!acc_r.we) rdt_r <= link.rdata;
                        if (link.err || (last && !repoll)) begin
                            err_r   <= link.err;
                            state_r <= FSQ_H_IDLE;
                        end else if (repoll) begin
                            acc_r <= acc_of(op_r, 1'b0, sz_r, adr_r, wdt_r);
                        end else begin
                            step_r <= 1'b1;
                            acc_r  <= acc_of(op_r, 1'b1, sz_r, adr_r, wdt_r);
                        end
                    end
                end
            endcase
        end
    end
endmodule : fsq_host
`default_nettype wire

// ### bench/fsq_link_asserts.sv
// Purpose: Link checker between host end and flash sequencer.
// Assumes: One clock; sees the link signals only.
// Notes:   Key tracking counts relock writes made while busy, which the device drops.
`timescale 1ns/1ps
`default_nettype none
`include "fsq_defines.svh"
module fsq_link_asserts (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        req,
    input wire logic        we,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        ack,
    input wire logic        err,
    input wire logic [31:0] rdata
);
    logic k1_r;
    logic unl_r;
    logic dead_r;
    wire  kw = we && addr == {`FSQ_REG_BASE, `FSQ_OFF_KEY};
    wire  fw = we && addr[31:24] == `FSQ_FLASH_HI;
    wire  lk = we && addr == {`FSQ_REG_BASE, `FSQ_OFF_CTL} && wdata[`FSQ_C_LOCK];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Key pair tracking: a good pair opens; a wrong key word, or any other access between the two words, kills
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            k1_r   <= 1'b0;
            unl_r  <= 1'b0;
            dead_r <= 1'b0;
        end else if (ack && !unl_r && !dead_r) begin
            k1_r   <= kw && wdata == `FSQ_FIRST_UNLOCK_WORD && !k1_r;
            unl_r  <= k1_r && kw && wdata == `FSQ_SECOND_UNLOCK_WORD;
            dead_r <= k1_r ? !(kw && wdata == `FSQ_SECOND_UNLOCK_WORD) : (kw && wdata != `FSQ_FIRST_UNLOCK_WORD);
        end else if (ack && unl_r && lk) begin
            unl_r  <= 1'b0;
        end
    end
    ack_after_req_a: assert property (ack |-> $past(req))
        else $error("ack without request");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("ack longer than a cycle");
    ack_latency_a: assert property (req && !ack |=> ack)
        else $error("request not answered next cycle");
    write_rdata_a: assert property (ack && we |-> rdata == 32'h0)
        else $error("write answered with data");
    err_ack_a: assert property (err |-> ack)
        else $error("error outside answer");
    dead_err_a: assert property (ack && dead_r |-> err)
        else $error("dead controller answered without error");
    key_ok_a: assert property (ack && kw && !dead_r && !k1_r && wdata == `FSQ_FIRST_UNLOCK_WORD |-> !err)
        else $error("first key refused");
    locked_quiet_a: assert property (ack && fw && !unl_r && !dead_r |-> !err)
        else $error("locked flash write errored");
endmodule : fsq_link_asserts
`default_nettype wire

// ### bench/flash_program_erase_sequencer_tb.sv
// Purpose: Drives both ends over AHB-Lite through lock, erase and program flows.
// Assumes: Default operation lengths; zero-wait host bus.
// Notes:   Busy length is counted cycle by cycle to catch chained operations.
`timescale 1ns/1ps
`default_nettype none
`include "fsq_defines.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module flash_program_erase_sequencer_tb;
    import fsq_pkg::*;
    localparam logic [31:0] KY = {`FSQ_REG_BASE, `FSQ_OFF_KEY};
    localparam logic [31:0] ST = {`FSQ_REG_BASE, `FSQ_OFF_STAT};
    localparam logic [31:0] CT = {`FSQ_REG_BASE, `FSQ_OFF_CTL};
    localparam logic [31:0] MK = {`FSQ_REG_BASE, `FSQ_OFF_MKEY};
    localparam logic [31:0] AD = {`FSQ_REG_BASE, `FSQ_OFF_ADDR};
    logic        ref_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, hrdy, hresp, op_busy;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    int          n_fail = 0, n_compared = 0, cyc = 0, busy_n = 0;
    fsq_link_if link ();
    fsq_host fsq_host_inst (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hrdy), .hreadyout(hrdy), .hresp, .hrdata, .link);
    fsq_device fsq_device_inst (.ref_clk, .sys_rst, .link, .arr_stb(), .arr_kind(),
        .arr_addr(), .arr_data(), .op_busy);
    fsq_link_asserts fsq_link_asserts_inst (.ref_clk, .sys_rst, .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .err(link.err), .rdata(link.rdata));
    always #20 ref_clk = ~ref_clk;
    // Cycle budget and busy length; a hang ends in the report
    always @(posedge ref_clk) begin
        cyc++;
        busy_n += op_busy;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (!hrdy);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (!hrdy);
        rd = hrdata;
    endtask : ahb
    // One link command; ex of x leaves the error bit unjudged
    task automatic op(input logic [2:0] o, input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] sz, input logic ex);
        ahb(1'b1, `FSQ_H_ADR, a);
        ahb(1'b1, `FSQ_H_WDT, d);
        ahb(1'b1, `FSQ_H_CMD, {22'h0, sz, 5'h0, o});
        do ahb(1'b0, `FSQ_H_STS, 32'h0); while (rd[`FSQ_HS_RUN]);
        if (ex !== 1'bx) `CHK("link err", ex, rd[`FSQ_HS_ERR])
        ahb(1'b0, `FSQ_H_RDT, 32'h0);
    endtask : op
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        op(`FSQ_OP_WR, a, d, `FSQ_SZ_WORD, 1'b0);
    endtask : wr
    task automatic idle();
        do op(`FSQ_OP_RD, ST, 32'h0, `FSQ_SZ_WORD, 1'b0); while (rd[`FSQ_S_BSY]);
    endtask : idle
    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        op(`FSQ_OP_WR, 32'h08000100, 32'h1234, `FSQ_SZ_HALF, 1'b0);
        `CHK("locked busy", 0, busy_n)
        op(`FSQ_OP_UNLK, KY, 32'h0, `FSQ_SZ_WORD, 1'b0);
        wr(CT, 32'h2);
        wr({`FSQ_REG_BASE, `FSQ_OFF_ADDR}, 32'h08000400);
        wr(CT, 32'h42);
        op(`FSQ_OP_RD, ST, 32'h0, `FSQ_SZ_WORD, 1'b0);
        `CHK("busy", 1'b1, rd[`FSQ_S_BSY])
        wr(CT, 32'h44);
        idle();
        `CHK("done", 1'b1, rd[`FSQ_S_EOP])
        `CHK("page len", 1'b1, busy_n inside {[256:257]})
        wr(ST, 32'h20);
        busy_n = 0;
        wr(CT, 32'h4);
        wr(CT, 32'h44);
        idle();
        `CHK("chip done", 1'b1, rd[`FSQ_S_EOP])
        `CHK("chip len", 1'b1, busy_n inside {[1024:1025]})
        wr(ST, 32'h20);
        wr(CT, 32'h1);
        op(`FSQ_OP_WR, 32'h08000200, 32'hBEEF, `FSQ_SZ_WORD, 1'b1);
        op(`FSQ_OP_WR, 32'h08000200, 32'hBEEF, `FSQ_SZ_HALF, 1'b0);
        idle();
        `CHK("prog done", 1'b1, rd[`FSQ_S_EOP])
        wr(ST, 32'h20);
        busy_n = 0;
        wr(CT, 32'h43);
        wr(CT, 32'h10040);
        wr(CT, 32'h80);
        wr(CT, 32'h42);
        `CHK("ignored start", 0, busy_n)
        // Fast flows need the main guard reopened and the fast guard opened
        op(`FSQ_OP_UNLK, KY, 32'h0, `FSQ_SZ_WORD, 1'b0);
        op(`FSQ_OP_FUNLK, MK, 32'h0, `FSQ_SZ_WORD, 1'b0);
        wr(CT, 32'h90000);
        idle();
        `CHK("buf clear done", 1'b1, rd[`FSQ_S_EOP])
        wr(ST, 32'h20);
        op(`FSQ_OP_WR, 32'h08000404, 32'hA5A5A5A5, `FSQ_SZ_WORD, 1'b0);
        wr(CT, 32'h50000);
        idle();
        `CHK("buf load done", 1'b1, rd[`FSQ_S_EOP])
        wr(ST, 32'h20);
        wr(AD, 32'h08000400);
        busy_n = 0;
        wr(CT, 32'h10040);
        idle();
        `CHK("fast prog len", 1'b1, busy_n inside {[144:145]})
        wr(ST, 32'h20);
        wr(CT, 32'h20000);
        busy_n = 0;
        wr(CT, 32'h20040);
        op(`FSQ_OP_WAIT, ST, 32'h0, `FSQ_SZ_WORD, 1'b0);
        `CHK("fast erase len", 1'b1, busy_n inside {[128:129]})
        op(`FSQ_OP_RD, ST, 32'h0, `FSQ_SZ_WORD, 1'b0);
        `CHK("done cleared", 1'b0, rd[`FSQ_S_EOP])
        wr(CT, 32'h8080);
        op(`FSQ_OP_WR, MK, 32'h0, `FSQ_SZ_WORD, 1'b0);
        op(`FSQ_OP_FUNLK, MK, 32'h0, `FSQ_SZ_WORD, 1'b0);
        op(`FSQ_OP_RD, CT, 32'h0, `FSQ_SZ_WORD, 1'b0);
        `CHK("fast guard held", 1'b1, rd[`FSQ_C_FAST_GUARD_BIT])
        op(`FSQ_OP_WR, KY, 32'h0, `FSQ_SZ_WORD, 1'bx);
        op(`FSQ_OP_RD, ST, 32'h0, `FSQ_SZ_WORD, 1'b1);
        conclude();
    end
endmodule : flash_program_erase_sequencer_tb
`default_nettype wire
